/* bvc_pkg.sv */
package bvc_pkg;

  localparam logic [7:0] SUB_ADDR_CTRL  = 8'h17;
  localparam logic [7:0] CTRL_RESET     = 8'h8f;
  localparam int         SKIP_BIT       = 7;
  localparam int         RSVD_BIT       = 6;
  localparam int         CODE_MSB       = 5;
  localparam int         CODE_WIDTH     = 6;
  localparam logic [5:0] CODE_FINE_LAST = 6'h32;
  localparam logic [7:0] RSVD_MASK      = 8'hbf;

  // Output voltage in millivolts: fine range, then coarse range.
  localparam logic [10:0] MV_FINE_BASE   = 11'h352;
  localparam logic [10:0] MV_FINE_STEP   = 11'h00a;
  localparam logic [10:0] MV_COARSE_BASE = 11'h546;
  localparam logic [10:0] MV_COARSE_STEP = 11'h019;

  localparam int CLK_HZ        = 125000000;
  localparam int BLANK_TIME_US = 5000;
  localparam int BLANK_CYCLES  = (CLK_HZ / 1000000) * BLANK_TIME_US;

  typedef struct packed {
    logic       skipEnable;
    logic       reserved;
    logic [5:0] code;
  } bvc_ctrl_type;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] subAddr;
    logic [7:0] wrData;
  } bvc_req_type;

endpackage

/* bvc_ctrl_reg.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - A write is taken only while the password unlock is satisfied.
// - Each taken write masks over- and under-voltage checks for 5 ms.
// - A new code reaches the converter only on an apply strobe.
// - Bit 7 is the light-load skip enable, read/write, reset to one.
// - Bits 5:0 give 0.850-1.350 V in 10 mV then up to 1.675 V in 25 mV.
// - The register sits at sub-address 0x17 and resets to 0x8f.
module bvc_ctrl_reg #(
  parameter int BLANK_CYCLES = bvc_pkg::BLANK_CYCLES
) (
  input  wire logic                 clk_sys,        // System clock, 125 MHz.
  input  wire logic                 reset,          // Synchronous reset.
  input  wire bvc_pkg::bvc_req_type req,            // Register access.
  input  wire logic                 unlockOk,       // Password unlock held.
  input  wire logic                 applyStrobe,    // Apply strobe pulse.
  input  wire logic                 altApplyStrobe, // Alternate apply pulse.
  output logic [7:0]                rdData_q,       // Read data.
  output logic                      rdValid_q,      // Read data valid.
  output logic                      wrRejected_q,   // Locked write refused.
  output logic                      skipEnable_q,   // Light-load skip.
  output logic [5:0]                activeCode_q,   // Applied code.
  output logic [10:0]               targetMv_q,     // Applied millivolts.
  output logic                      blanking_q      // Supervision masked.
);

  // The blanking counter is twenty bits wide, enough for 5 ms at 125 MHz;
  // a longer window is refused here rather than silently cut short.
  if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << 20)) begin : g_blankRange
    $error("BLANK_CYCLES out of range");
  end

  bvc_pkg::bvc_ctrl_type ctrl_q;
  logic [19:0]           blankCnt_q;

  wire hit        = req.subAddr == bvc_pkg::SUB_ADDR_CTRL;
  wire wrHit      = req.wrEn && hit;
  wire wrTaken    = wrHit && unlockOk;
  wire rdHit      = req.rdEn && hit;
  wire applyNow   = applyStrobe || altApplyStrobe;
  wire [7:0] wrMasked = req.wrData & bvc_pkg::RSVD_MASK;
  wire [7:0] rdWord = ctrl_q & bvc_pkg::RSVD_MASK;
  wire [5:0] nextActive = applyNow ? ctrl_q.code : activeCode_q;
  wire       fineRange = nextActive <= bvc_pkg::CODE_FINE_LAST;
  wire [10:0] fineMv = bvc_pkg::MV_FINE_BASE
                     + 11'(nextActive) * bvc_pkg::MV_FINE_STEP;
  wire [10:0] coarseMv = bvc_pkg::MV_COARSE_BASE
                       + 11'(nextActive - bvc_pkg::CODE_FINE_LAST)
                       * bvc_pkg::MV_COARSE_STEP;
  wire [10:0] mvNext = fineRange ? fineMv : coarseMv;
  wire [19:0] blankLoad = 20'(BLANK_CYCLES - 1);
  wire        blankDone = blankCnt_q == 20'h00000;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= bvc_pkg::CTRL_RESET;
    end else if (wrTaken) begin
      ctrl_q <= wrMasked;
    end
  end

  // The applied code only moves on a strobe, so a half-finished sequence
  // of writes never disturbs the converter output.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      activeCode_q <= bvc_pkg::CTRL_RESET[bvc_pkg::CODE_MSB:0];
      targetMv_q   <= bvc_pkg::MV_FINE_BASE
                    + 11'(bvc_pkg::CTRL_RESET[bvc_pkg::CODE_MSB:0])
                    * bvc_pkg::MV_FINE_STEP;
    end else begin
      activeCode_q <= nextActive;
      targetMv_q   <= mvNext;
    end
  end

  // A taken write restarts the full window even if one is running.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      blankCnt_q <= 20'h00000;
      blanking_q <= 1'b0;
    end else if (wrTaken) begin
      blankCnt_q <= blankLoad;
      blanking_q <= 1'b1;
    end else if (!blankDone) begin
      blankCnt_q <= blankCnt_q - 20'h00001;
      blanking_q <= 1'b1;
    end else begin
      blanking_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_q     <= 8'h00;
      rdValid_q    <= 1'b0;
      wrRejected_q <= 1'b0;
      skipEnable_q <= bvc_pkg::CTRL_RESET[bvc_pkg::SKIP_BIT];
    end else begin
      rdData_q     <= rdHit ? rdWord : 8'h00;
      rdValid_q    <= rdHit;
      wrRejected_q <= wrHit && !unlockOk;
      skipEnable_q <= ctrl_q.skipEnable;
    end
  end

  // These checks look only at the register's own ports and state, so they
  // travel with the block into any larger design.
  a_locked_write: assert property (
    @(posedge clk_sys) disable iff (reset)
    (req.wrEn && hit && !unlockOk) |=> $stable(ctrl_q))
    else $error("locked write changed the register");

  a_write_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    !wrTaken |=> $stable(ctrl_q))
    else $error("register changed without a taken write");

  a_reject_flag: assert property (
    @(posedge clk_sys) disable iff (reset)
    (wrHit && !unlockOk) |=> wrRejected_q)
    else $error("locked write not flagged");

  a_reject_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(wrHit && !unlockOk) |=> !wrRejected_q)
    else $error("reject flag without locked write");

  a_blank_start: assert property (
    @(posedge clk_sys) disable iff (reset)
    wrTaken |=> blanking_q [*8])
    else $error("blanking did not start on write");

  a_blank_load: assert property (
    @(posedge clk_sys) disable iff (reset)
    wrTaken |=> blankCnt_q == blankLoad)
    else $error("blanking window not restarted");

  a_blank_end: assert property (
    @(posedge clk_sys) disable iff (reset)
    (blanking_q && blankDone && !wrTaken) |=> !blanking_q)
    else $error("blanking did not end");

  a_locked_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    (wrHit && !unlockOk && !blanking_q) |=> !blanking_q)
    else $error("locked write started blanking");

  a_apply_hold: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!applyStrobe && !altApplyStrobe) |=> $stable(activeCode_q))
    else $error("code applied without strobe");

  a_apply_take: assert property (
    @(posedge clk_sys) disable iff (reset)
    (applyStrobe || altApplyStrobe) |=> activeCode_q == $past(ctrl_q.code))
    else $error("strobe did not apply code");

  a_skip_follow: assert property (
    @(posedge clk_sys) disable iff (reset)
    wrTaken ##1 1'b1 |=> skipEnable_q == $past(req.wrData[7], 2))
    else $error("skip enable not written");

  a_mv_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    (activeCode_q == 6'h00) |-> targetMv_q == 11'h352)
    else $error("bottom code voltage wrong");

  a_mv_fine_last: assert property (
    @(posedge clk_sys) disable iff (reset)
    (activeCode_q == 6'h32) |-> targetMv_q == 11'h546)
    else $error("last fine code voltage wrong");

  a_mv_coarse_first: assert property (
    @(posedge clk_sys) disable iff (reset)
    (activeCode_q == 6'h33) |-> targetMv_q == 11'h55f)
    else $error("first coarse code voltage wrong");

  a_mv_map: assert property (
    @(posedge clk_sys) disable iff (reset)
    (activeCode_q == 6'h3f) |-> targetMv_q == 11'h68b)
    else $error("top code voltage wrong");

  a_rsvd_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    rdValid_q |-> !rdData_q[bvc_pkg::RSVD_BIT])
    else $error("reserved bit read as one");

  a_write_store: assert property (
    @(posedge clk_sys) disable iff (reset)
    wrTaken |=> ctrl_q == $past(req.wrData & bvc_pkg::RSVD_MASK))
    else $error("written value not stored");

  a_read_back: assert property (
    @(posedge clk_sys) disable iff (reset)
    (rdHit && !wrTaken) |=> rdData_q == $past(rdWord))
    else $error("read data wrong");

  a_read_idle: assert property (
    @(posedge clk_sys) disable iff (reset)
    !rdHit |=> (!rdValid_q && rdData_q == 8'h00))
    else $error("read data without a read hit");

  a_other_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    (req.wrEn && !hit) |=> $stable(ctrl_q))
    else $error("write to other address changed the register");

  a_reset_reg: assert property (
    @(posedge clk_sys)
    reset |=> ctrl_q == bvc_pkg::CTRL_RESET)
    else $error("register not at reset value");

  a_reset_out: assert property (
    @(posedge clk_sys) reset |=>
      (activeCode_q == bvc_pkg::CTRL_RESET[bvc_pkg::CODE_MSB:0]
       && skipEnable_q == bvc_pkg::CTRL_RESET[bvc_pkg::SKIP_BIT]
       && !blanking_q && targetMv_q == 11'h3e8))
    else $error("outputs not at reset values");

endmodule

`default_nettype wire

/* bvc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bvc_host_model (
  input  wire logic           clk_sys,       // System clock.
  output bvc_pkg::bvc_req_type req,          // Register access.
  output logic                unlockOk,      // Unlock held.
  output logic                applyStrobe,   // Apply pulse.
  output logic                altApplyStrobe // Alternate apply.
);
  initial begin
    req = '0;
    unlockOk = 1'h0;
    {altApplyStrobe, applyStrobe} = 2'h0;
  end
  // Released address and data lines are inverted and the enables cleared, so a stale value can never match.
  task automatic xfer(input logic w, input logic [7:0] a, d, input logic u);
    @(negedge clk_sys);
    req = '{w, !w, a, d};
    unlockOk = u;
    @(negedge clk_sys);
    req = '{1'h0, 1'h0, ~a, ~d};
    unlockOk = 1'h0;
  endtask
  task automatic go(input logic alt);
    @(negedge clk_sys);
    {altApplyStrobe, applyStrobe} = {alt, !alt};
    @(negedge clk_sys);
    {altApplyStrobe, applyStrobe} = 2'h0;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clk_sys = 1'h0;
  logic                 reset = 1'h1;
  bvc_pkg::bvc_req_type req;
  logic                 unlock, apply, altApply, rdValid, rej, skip, blank;
  logic [7:0]           rdData, d;
  logic [5:0]           code = 6'h0f, act;
  logic [5:0]           corner [4] = '{6'h32, 6'h33, 6'h3f, 6'h00};
  logic [10:0]          mv;
  logic [31:0]          lfsr = 32'hf9ba;
  int                   errTotal = 0, testsRun = 0, cyc = 0;
  always #4 clk_sys = !clk_sys;
  bvc_ctrl_reg #(.BLANK_CYCLES(20)) i_dut (.clk_sys(clk_sys),
    .reset(reset), .req(req), .unlockOk(unlock), .applyStrobe(apply),
    .altApplyStrobe(altApply), .rdData_q(rdData), .rdValid_q(rdValid),
    .wrRejected_q(rej), .skipEnable_q(skip), .activeCode_q(act),
    .targetMv_q(mv), .blanking_q(blank));
  bvc_host_model i_host (.clk_sys(clk_sys), .req(req), .unlockOk(unlock),
    .applyStrobe(apply), .altApplyStrobe(altApply));
  function automatic logic [10:0] expMv(input logic [5:0] c);
    return (c <= 6'h32) ? 11'h352 + 11'(c) * 11'h00a
                        : 11'h546 + 11'(c - 6'h32) * 11'h019;
  endfunction
  function automatic logic [31:0] nextLfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [10:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errTotal++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'h0;
    i_host.xfer(1'h0, 8'h17, 8'h00, 1'h0);
    chk("rst read", {rdValid, rdData}, 11'h18f);
    chk("rst skip", {skip, act, blank}, {1'h1, 6'h0f, 1'h0});
    chk("rst mv", mv, 11'h3e8);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      lfsr = nextLfsr(lfsr);
      d = {lfsr[7:6], (i < 4) ? corner[i] : lfsr[5:0]};
      i_host.xfer(1'h1, 8'h17, d, 1'h1);
      @(negedge clk_sys);
      chk("blank", blank, 1'h1);
      chk("skip", skip, d[7]);
      chk("held", act, code);
      i_host.xfer(1'h0, 8'h17, 8'h00, 1'h0);
      chk("read", {rdValid, rdData}, {1'h1, d & 8'hbf});
      i_host.go(i[0]);
      @(negedge clk_sys);
      code = d[5:0];
      chk("code", act, code);
      chk("mv", mv, expMv(code));
      $display("write test %0d done", i);
    end
    repeat (24) @(negedge clk_sys);
    chk("blank end", blank, 1'h0);
    i_host.xfer(1'h1, 8'h17, ~d, 1'h0);
    chk("rejected", rej, 1'h1);
    @(negedge clk_sys);
    chk("no blank", blank, 1'h0);
    i_host.xfer(1'h1, 8'h18, ~d, 1'h1);
    chk("other wr", {rej, blank}, 2'h0);
    i_host.xfer(1'h0, 8'h17, 8'h00, 1'h0);
    chk("locked", rdData, d & 8'hbf);
    i_host.xfer(1'h0, 8'h16, 8'h00, 1'h0);
    chk("other", {rdValid, rdData}, 11'h000);
    $display("lock test done");
    summarize();
  end
endmodule
`default_nettype wire
